// [ccs_device.sv]
`timescale 1ns/1ps
module ccs_device
  import ccs_pkg::*;
#(
  parameter int SW_CYC  = ccs_pkg::SWITCH_CYC,
  parameter int MS_CYC  = ccs_pkg::MAIN_STAB_CYC,
  parameter int IS_CYC  = ccs_pkg::INT_STAB_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  input  wire logic       int_osc_clk_i,
  input  wire logic       x1_clk_i,
  input  wire logic       ext_main_clk_i,
  input  wire logic       xt1_clk_i,
  input  wire logic       ext_sub_clk_i,
  input  wire logic       supply_ok_i,
  input  wire logic       wake_i,
  input  wire logic       volt_detect_default_start_i,
  output logic            cpu_clk_o,
  output logic            periph_clk_o,
  ccs_if.dev              bus
);
  import ccs_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int PW = 7;
  logic [PW-1:0] pin_in;
  logic [PW-1:0] s1_r, s2_r, s3_r, pin_r;
  assign pin_in = {wake_i, supply_ok_i, ext_sub_clk_i, xt1_clk_i,
                   ext_main_clk_i, x1_clk_i, int_osc_clk_i};

  // A change is taken only once the second and third stages agree
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      pin_r <= '0;
    end else if (ce_i) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < PW; i++) begin
        if (s2_r[i] == s3_r[i]) pin_r[i] <= s3_r[i];
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic       hs_sel_r, main_sel_r, hs_locked_r;
  logic       sub_start_r, cpu_sub_r;
  logic [3:0] op_mode_r;
  logic       main_stop_r, int_stop_r;
  logic [7:0] wd;
  assign wd = bus.reg_wdata;

  // Control bits and the once-only high-speed select
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hs_sel_r    <= MCM_RST[HS_SEL_BIT];
      main_sel_r  <= MCM_RST[MAIN_SEL_BIT];
      hs_locked_r <= 1'b0;
      sub_start_r <= PCC_RST[SUB_START_BIT];
      cpu_sub_r   <= PCC_RST[CPU_SUB_BIT];
      op_mode_r   <= OSCC_RST[7:4];
      main_stop_r <= MOC_RST[MAIN_STOP_BIT];
      int_stop_r  <= RCM_RST[INT_STOP_BIT];
    end else if (ce_i && bus.reg_wr) begin
      unique case (bus.reg_idx)
        MAIN_CLOCK_MODE_IDX: begin
          main_sel_r <= wd[MAIN_SEL_BIT];
          if (!hs_locked_r && wd[HS_SEL_BIT] != hs_sel_r) begin
            hs_sel_r    <= wd[HS_SEL_BIT];
            hs_locked_r <= 1'b1;
          end
        end
        PROC_CLOCK_CTRL_IDX: begin
          sub_start_r <= wd[SUB_START_BIT];
          cpu_sub_r   <= wd[CPU_SUB_BIT];
        end
        CLOCK_OP_MODE_IDX: op_mode_r   <= wd[7:4];
        MAIN_OSC_CTRL_IDX: main_stop_r <= wd[MAIN_STOP_BIT];
        INT_OSC_MODE_IDX:  int_stop_r  <= wd[INT_STOP_BIT];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Source selection
  // ****************************************************************
  ccs_state_t st_r;
  ccs_src_t   cpu_src_r, per_src_r, cpu_want, per_want;
  logic       stopped;
  assign stopped = (st_r == ST_STOP_INT) || (st_r == ST_STOP_HS);

  // The main high-speed path, X1 or the external main clock
  function automatic ccs_src_t hs_src(input logic ext);
    return ext ? SRC_EXT_MAIN : SRC_X1;
  endfunction

  // Wanted CPU source from the control bits
  always_comb begin
    if (cpu_sub_r)
      cpu_want = (sub_start_r || !op_mode_r[SUB_EXT_BIT-4]) ? SRC_XT1 : SRC_EXT_SUB;
    else if (main_sel_r && hs_sel_r)
      cpu_want = hs_src(op_mode_r[MAIN_EXT_BIT-4]);
    else
      cpu_want = SRC_INT;
    per_want = hs_sel_r ? hs_src(op_mode_r[MAIN_EXT_BIT-4]) : SRC_INT;
  end

  // Stabilisation counters for the main and internal oscillators
  logic [15:0] ms_cnt_r, is_cnt_r;
  logic        ms_done, is_done;
  assign ms_done = (ms_cnt_r == 16'(MS_CYC));
  assign is_done = (is_cnt_r == 16'(IS_CYC));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ms_cnt_r <= '0;
      is_cnt_r <= '0;
    end else if (ce_i) begin
      if (main_stop_r || !op_mode_r[MAIN_PIN_BIT-4] || op_mode_r[MAIN_EXT_BIT-4] || stopped)
        ms_cnt_r <= '0;
      else if (!ms_done)
        ms_cnt_r <= ms_cnt_r + 16'h0001;
      if (int_stop_r || stopped)
        is_cnt_r <= '0;
      else if (!is_done)
        is_cnt_r <= is_cnt_r + 16'h0001;
    end
  end

  // Switch delay: the old clock runs on before the change is made
  logic [7:0] sw_cnt_r;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i)
      sw_cnt_r <= '0;
    else if (ce_i) begin
      if (cpu_want == cpu_src_r)
        sw_cnt_r <= '0;
      else if (sw_cnt_r != 8'(SW_CYC))
        sw_cnt_r <= sw_cnt_r + 8'h01;
    end
  end

  // Changing only while both old and new sources are low keeps any
  // runt pulse off the gated clocks
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cpu_src_r <= SRC_INT;
      per_src_r <= SRC_INT;
    end else if (ce_i) begin
      if (sw_cnt_r == 8'(SW_CYC) && !pin_r[cpu_src_r] && !pin_r[cpu_want])
        cpu_src_r <= cpu_want;
      if (per_want != per_src_r && !pin_r[per_src_r] && !pin_r[per_want])
        per_src_r <= per_want;
    end
  end

  // ****************************************************************
  // CPU clock state
  // ****************************************************************
  ccs_state_t run_st;
  always_comb begin
    unique case (cpu_src_r)
      SRC_INT:              run_st = ST_INT_RUN;
      SRC_X1, SRC_EXT_MAIN: run_st = ST_HS_RUN;
      default:              run_st = ST_SUB_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i)
      st_r <= ST_RESET;
    else if (ce_i) begin
      unique case (st_r)
        ST_RESET:
          if (!volt_detect_default_start_i || pin_r[5]) st_r <= ST_INT_RUN;
        ST_INT_RUN, ST_HS_RUN, ST_SUB_RUN:
          if (bus.halt_req) begin
            st_r <= (run_st == ST_INT_RUN) ? ST_HALT_INT :
                    (run_st == ST_HS_RUN)  ? ST_HALT_HS  : ST_HALT_SUB;
          end else if (bus.stop_req && run_st != ST_SUB_RUN) begin
            st_r <= (run_st == ST_INT_RUN) ? ST_STOP_INT : ST_STOP_HS;
          end else
            st_r <= run_st;
        ST_HALT_INT, ST_HALT_HS, ST_HALT_SUB, ST_STOP_INT, ST_STOP_HS:
          if (pin_r[6]) st_r <= run_st;
      endcase
    end
  end

  // ****************************************************************
  // Gated clock outputs and register answers
  // ****************************************************************
  logic cpu_run, per_run;
  assign cpu_run = (st_r == ST_INT_RUN) || (st_r == ST_HS_RUN) || (st_r == ST_SUB_RUN);
  assign per_run = (st_r != ST_RESET) && !stopped;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cpu_clk_o    <= 1'b0;
      periph_clk_o <= 1'b0;
    end else if (ce_i) begin
      cpu_clk_o    <= cpu_run & pin_r[cpu_src_r];
      periph_clk_o <= per_run & pin_r[per_src_r];
    end
  end

  logic main_clk_status, cpu_clk_status;
  assign main_clk_status = (cpu_src_r == SRC_X1) || (cpu_src_r == SRC_EXT_MAIN);
  assign cpu_clk_status = (cpu_src_r == SRC_XT1) || (cpu_src_r == SRC_EXT_SUB);

  // Reads answer one cycle after the strobe; writes are acknowledged too
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus.reg_ack   <= 1'b0;
      bus.reg_rdata <= '0;
      bus.cpu_state <= '0;
    end else if (ce_i) begin
      bus.reg_ack   <= bus.reg_wr | bus.reg_rd;
      bus.cpu_state <= st_r;
      if (bus.reg_rd) begin
        unique case (bus.reg_idx)
          MAIN_CLOCK_MODE_IDX:
            bus.reg_rdata <= {5'h00, hs_sel_r, main_clk_status, main_sel_r};
          PROC_CLOCK_CTRL_IDX:
            bus.reg_rdata <= {1'b0, sub_start_r, cpu_clk_status, cpu_sub_r, 4'h0};
          CLOCK_OP_MODE_IDX:   bus.reg_rdata <= {op_mode_r, 4'h0};
          MAIN_OSC_CTRL_IDX:   bus.reg_rdata <= {main_stop_r, 7'h00};
          INT_OSC_MODE_IDX:    bus.reg_rdata <= {is_done, 6'h00, int_stop_r};
          OSC_STAB_STAT_IDX:   bus.reg_rdata <= {7'h00, ms_done};
          default:             bus.reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // ccs_device

// [ccs_pkg.sv]
package ccs_pkg;

  // ****************************************************************
  // Register indexes on the device's own register port
  // ****************************************************************
  localparam logic [2:0] MAIN_CLOCK_MODE_IDX = 3'h0;
  localparam logic [2:0] PROC_CLOCK_CTRL_IDX = 3'h1;
  localparam logic [2:0] CLOCK_OP_MODE_IDX   = 3'h2;
  localparam logic [2:0] MAIN_OSC_CTRL_IDX   = 3'h3;
  localparam logic [2:0] INT_OSC_MODE_IDX    = 3'h4;
  localparam logic [2:0] OSC_STAB_STAT_IDX   = 3'h5;
  localparam int         REG_NUM             = 6;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int HS_SEL_BIT     = 2;  // main_clock_mode_reg
  localparam int MCS_BIT        = 1;
  localparam int MAIN_SEL_BIT   = 0;
  localparam int SUB_START_BIT  = 6;  // processor_clock_ctrl_reg
  localparam int CLS_BIT        = 5;
  localparam int CPU_SUB_BIT    = 4;
  localparam int MAIN_EXT_BIT   = 7;  // clock_op_mode_reg
  localparam int MAIN_PIN_BIT   = 6;
  localparam int SUB_EXT_BIT    = 5;
  localparam int SUB_PIN_BIT    = 4;
  localparam int MAIN_STOP_BIT  = 7;  // main_osc_ctrl_reg
  localparam int INT_STABLE_BIT = 7;  // internal_osc_mode_reg
  localparam int INT_STOP_BIT   = 0;
  localparam int OSC_STAB_COUNTER_STATUS_DONE_BIT  = 0;  // osc_stab_counter_status

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] MCM_RST  = 8'h00;
  localparam logic [7:0] PCC_RST  = 8'h00;
  localparam logic [7:0] OSCC_RST = 8'h00;
  localparam logic [7:0] MOC_RST  = 8'h80;
  localparam logic [7:0] RCM_RST  = 8'h00;

  // ****************************************************************
  // Timing, clk_i at 10 MHz
  // ****************************************************************
  localparam int CLK_NS        = 100;
  localparam int SWITCH_NS     = 800;
  localparam int SWITCH_CYC    = (SWITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAIN_STAB_NS  = 25600;
  localparam int MAIN_STAB_CYC = (MAIN_STAB_NS + CLK_NS - 1) / CLK_NS;
  localparam int INT_STAB_NS   = 3200;
  localparam int INT_STAB_CYC  = (INT_STAB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUB_WAIT_NS   = 51200;
  localparam int SUB_WAIT_CYC  = (SUB_WAIT_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    SRC_INT, SRC_X1, SRC_EXT_MAIN, SRC_XT1, SRC_EXT_SUB
  } ccs_src_t;

  typedef enum logic [3:0] {
    ST_RESET, ST_INT_RUN, ST_HS_RUN, ST_SUB_RUN, ST_HALT_INT,
    ST_HALT_HS, ST_HALT_SUB, ST_STOP_INT, ST_STOP_HS
  } ccs_state_t;

  // Controller command codes
  localparam logic [2:0] CMD_HALT = 3'h5;
  localparam logic [2:0] CMD_STOP = 3'h6;

  typedef enum logic [1:0] {K_END, K_WRITE, K_POLL, K_WAIT} ccs_kind_t;

  typedef struct packed {
    ccs_kind_t  kind;
    logic [2:0] idx;
    logic [2:0] bitn;
    logic       val;
  } ccs_step_t;

  // Avalon byte offsets of the controller
  localparam logic [3:0] CTL_CMD_OFS  = 4'h0;
  localparam logic [3:0] CTL_STAT_OFS = 4'h4;

endpackage

// [ccs_if.sv]
`timescale 1ns/1ps
interface ccs_if;
  logic       reg_wr;     // One-cycle write strobe
  logic       reg_rd;     // One-cycle read strobe
  logic [2:0] reg_idx;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_ack;    // One-cycle answer
  logic       halt_req;
  logic       stop_req;
  logic [3:0] cpu_state;

  modport dev  (input reg_wr, reg_rd, reg_idx, reg_wdata, halt_req, stop_req,
                output reg_rdata, reg_ack, cpu_state);
  modport host (output reg_wr, reg_rd, reg_idx, reg_wdata, halt_req, stop_req,
                input reg_rdata, reg_ack, cpu_state);
endinterface

// [ccs_host.sv]
`timescale 1ns/1ps
module ccs_host
  import ccs_pkg::*;
#(
  parameter int SUB_CYC = ccs_pkg::SUB_WAIT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  ccs_if.host              bus
);
  import ccs_pkg::*;

  // ****************************************************************
  // Command sequences, one step per index
  // ****************************************************************
  function automatic ccs_step_t stp(input ccs_kind_t k, input logic [2:0] i,
                                    input int b, input logic v);
    return '{kind: k, idx: i, bitn: 3'(b), val: v};
  endfunction

  function automatic ccs_step_t seq_step(input logic [2:0] cmd, input logic [3:0] n);
    ccs_step_t s;
    s = stp(K_END, 3'h0, 0, 1'b0);
    unique case (cmd)
      3'h0: unique case (n)
        4'h0: s = stp(K_WRITE, INT_OSC_MODE_IDX, INT_STOP_BIT, 1'b0);
        4'h1: s = stp(K_POLL, INT_OSC_MODE_IDX, INT_STABLE_BIT, 1'b1);
        4'h2: s = stp(K_WRITE, MAIN_CLOCK_MODE_IDX, MAIN_SEL_BIT, 1'b0);
        4'h3: s = stp(K_WRITE, PROC_CLOCK_CTRL_IDX, CPU_SUB_BIT, 1'b0);
        // Busy also covers the run-on of the old clock
        4'h4: s = stp(K_POLL, PROC_CLOCK_CTRL_IDX, CLS_BIT, 1'b0);
        4'h5: s = stp(K_POLL, MAIN_CLOCK_MODE_IDX, MCS_BIT, 1'b0);
        default: ;
      endcase
      3'h1, 3'h2: unique case (n)
        4'h0: s = stp(K_WRITE, CLOCK_OP_MODE_IDX, MAIN_EXT_BIT, cmd[1]);
        4'h1: s = stp(K_WRITE, CLOCK_OP_MODE_IDX, MAIN_PIN_BIT, 1'b1);
        4'h2: s = stp(K_WRITE, MAIN_OSC_CTRL_IDX, MAIN_STOP_BIT, 1'b0);
        4'h3: s = cmd[1] ? stp(K_WRITE, MAIN_OSC_CTRL_IDX, MAIN_STOP_BIT, 1'b0)
                         : stp(K_POLL, OSC_STAB_STAT_IDX, OSC_STAB_COUNTER_STATUS_DONE_BIT, 1'b1);
        4'h4: s = stp(K_WRITE, MAIN_CLOCK_MODE_IDX, HS_SEL_BIT, 1'b1);
        4'h5: s = stp(K_WRITE, MAIN_CLOCK_MODE_IDX, MAIN_SEL_BIT, 1'b1);
        4'h6: s = stp(K_WRITE, PROC_CLOCK_CTRL_IDX, CPU_SUB_BIT, 1'b0);
        4'h7: s = stp(K_POLL, MAIN_CLOCK_MODE_IDX, MCS_BIT, 1'b1);
        default: ;
      endcase
      3'h3, 3'h4: unique case (n)
        4'h0: s = stp(K_WRITE, PROC_CLOCK_CTRL_IDX, SUB_START_BIT, 1'b0);
        4'h1: s = stp(K_WRITE, CLOCK_OP_MODE_IDX, SUB_EXT_BIT, cmd[2]);
        4'h2: s = stp(K_WRITE, CLOCK_OP_MODE_IDX, SUB_PIN_BIT, 1'b1);
        4'h3: s = cmd[2] ? stp(K_WRITE, CLOCK_OP_MODE_IDX, SUB_PIN_BIT, 1'b1)
                         : stp(K_WAIT, 3'h0, 0, 1'b0);
        4'h4: s = stp(K_WRITE, PROC_CLOCK_CTRL_IDX, CPU_SUB_BIT, 1'b1);
        4'h5: s = stp(K_POLL, PROC_CLOCK_CTRL_IDX, CLS_BIT, 1'b1);
        default: ;
      endcase
      default: ;
    endcase
    return s;
  endfunction

  // ****************************************************************
  // Avalon slave: commands in, status out
  // ****************************************************************
  typedef enum logic [1:0] {H_IDLE, H_FETCH, H_BUS, H_DELAY} ccs_hst_t;
  ccs_hst_t    hst_r;
  logic [2:0]  cmd_r;
  logic [3:0]  n_r;
  logic        go_r;
  logic [7:0]  shadow_r [REG_NUM];
  logic [19:0] dly_r;
  ccs_step_t   cur;
  logic [7:0]  newv;

  assign cur  = seq_step(cmd_r, n_r);
  always_comb begin
    newv = shadow_r[cur.idx];
    newv[cur.bitn] = cur.val;
  end

  // Answer at the edge after the request; busy drops new commands
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      go_r            <= 1'b0;
      cmd_r           <= 3'h0;
    end else if (ce_i) begin
      go_r            <= 1'b0;
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if ((avs_read | avs_write) && avs_waitrequest) begin
        avs_readdata <= {23'h0, hst_r != H_IDLE, 4'h0, bus.cpu_state};
        if (avs_write && avs_address == CTL_CMD_OFS && hst_r == H_IDLE) begin
          cmd_r <= avs_writedata[2:0];
          go_r  <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Sequencer on the device register port
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hst_r         <= H_IDLE;
      n_r           <= '0;
      dly_r         <= '0;
      bus.reg_wr    <= 1'b0;
      bus.reg_rd    <= 1'b0;
      bus.reg_idx   <= '0;
      bus.reg_wdata <= '0;
      bus.halt_req  <= 1'b0;
      bus.stop_req  <= 1'b0;
      shadow_r      <= '{MCM_RST, PCC_RST, OSCC_RST, MOC_RST, RCM_RST, 8'h00};
    end else if (ce_i) begin
      bus.reg_wr   <= 1'b0;
      bus.reg_rd   <= 1'b0;
      bus.halt_req <= 1'b0;
      bus.stop_req <= 1'b0;
      unique case (hst_r)
        H_IDLE: if (go_r) begin
          n_r          <= '0;
          bus.halt_req <= (cmd_r == CMD_HALT);
          bus.stop_req <= (cmd_r == CMD_STOP);
          if (cmd_r <= 3'h4) hst_r <= H_FETCH;
        end
        H_FETCH: begin
          bus.reg_idx <= cur.idx;
          unique case (cur.kind)
            K_END: hst_r <= H_IDLE;
            K_WRITE: if (newv == shadow_r[cur.idx]) n_r <= n_r + 4'h1;
              else begin                             // Skip writes already in place
                shadow_r[cur.idx] <= newv;
                bus.reg_wdata     <= newv;
                bus.reg_wr        <= 1'b1;
                hst_r             <= H_BUS;
              end
            K_POLL: begin
              bus.reg_rd <= 1'b1;
              hst_r      <= H_BUS;
            end
            K_WAIT: begin
              dly_r <= 20'(SUB_CYC);
              hst_r <= H_DELAY;
            end
          endcase
        end
        H_BUS: if (bus.reg_ack) begin
          if (cur.kind == K_POLL && bus.reg_rdata[cur.bitn] != cur.val)
            bus.reg_rd <= 1'b1;                      // Poll again
          else begin
            n_r   <= n_r + 4'h1;
            hst_r <= H_FETCH;
          end
        end
        H_DELAY: if (dly_r == '0) begin
          n_r   <= n_r + 4'h1;
          hst_r <= H_FETCH;
        end else
          dly_r <= dly_r - 20'h00001;
      endcase
    end
  end

endmodule // ccs_host

// [ccs_assertions.sv]
`timescale 1ns/1ps
module ccs_assertions
  import ccs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [2:0] reg_idx,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_ack,
  input  wire logic       halt_req,
  input  wire logic       stop_req,
  input  wire logic [3:0] cpu_state
);
  // ****************************************************************
  // Shadow of the mode register as the wire says it should read
  // ****************************************************************
  logic hs_r;
  logic lock_r;
  logic ms_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // High-speed select takes only its first change after reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hs_r   <= 1'b0;
      lock_r <= 1'b0;
    end else if (reg_wr && reg_idx == MAIN_CLOCK_MODE_IDX && !lock_r
                 && reg_wdata[HS_SEL_BIT] != hs_r) begin
      hs_r   <= reg_wdata[HS_SEL_BIT];
      lock_r <= 1'b1;
    end
  end

  // Main select follows every write
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ms_r <= 1'b0;
    end else if (reg_wr && reg_idx == MAIN_CLOCK_MODE_IDX) begin
      ms_r <= reg_wdata[MAIN_SEL_BIT];
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  ack_follows_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("register strobe not answered next cycle");
  ack_caused_a: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("register answer without a strobe");
  strobe_excl_a: assert property (!(reg_wr && reg_rd))
    else $error("read and write strobes together");
  reset_exit_a: assert property (
    cpu_state == ST_RESET |=> cpu_state inside {ST_RESET, ST_INT_RUN})
    else $error("reset state left to a wrong state");
  hs_once_a: assert property (
    reg_rd && reg_idx == MAIN_CLOCK_MODE_IDX |=> reg_rdata[HS_SEL_BIT] == hs_r)
    else $error("high-speed select changed more than once");
  main_sel_a: assert property (
    reg_rd && reg_idx == MAIN_CLOCK_MODE_IDX |=> reg_rdata[MAIN_SEL_BIT] == ms_r)
    else $error("main select bit reads wrong");
  halt_int_a: assert property (
    halt_req && cpu_state == ST_INT_RUN |-> ##[1:4] cpu_state == ST_HALT_INT)
    else $error("halt from internal clock missed");
  halt_stay_a: assert property (
    cpu_state == ST_HALT_HS |=> cpu_state inside {ST_HALT_HS, ST_HS_RUN})
    else $error("high-speed halt left to a wrong state");
  stop_hs_a: assert property (
    stop_req && cpu_state == ST_HS_RUN |-> ##[1:4] cpu_state == ST_STOP_HS)
    else $error("stop from high-speed clock missed");
  stop_origin_a: assert property (
    cpu_state == ST_STOP_INT |-> $past(cpu_state) inside {ST_STOP_INT, ST_INT_RUN})
    else $error("internal stop entered from a wrong state");
endmodule // ccs_assertions

// [tb.sv]
`timescale 1ns/1ps
module tb;
  import ccs_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        supply_ok_i = 1'b1;
  logic        wake_i = 1'b0;
  logic        strap = 1'b0;
  logic [7:0]  cnt = 8'h00;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic        avs_writedata_chk = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        cpu_clk;
  logic        periph_clk;
  logic [31:0] q;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'hb449;
  ccs_state_t  cur = ST_INT_RUN;
  int          n_errors = 0;
  int          n_tests = 0;
  int          c;
  int          c_list[11] = '{5, 6, 1, 5, 6, 0, 2, 3, 5, 0, 4};
  ccs_if bus();

  always #50 clk_i = ~clk_i;
  // Slow source clocks, each at its own rate so a wrong mux shows
  always @(posedge clk_i) cnt <= cnt + 8'h01;

  ccs_device #(.MS_CYC(16)) ccs_device_inst (.clk_i, .sys_rst_i, .ce_i(1'b1),
    .int_osc_clk_i(cnt[2]), .x1_clk_i(cnt[3]), .ext_main_clk_i(cnt[4]),
    .xt1_clk_i(cnt[5]), .ext_sub_clk_i(cnt[6]), .supply_ok_i, .wake_i,
    .volt_detect_default_start_i(strap), .cpu_clk_o(cpu_clk),
    .periph_clk_o(periph_clk), .bus(bus));
  ccs_host #(.SUB_CYC(4)) ccs_host_inst (.clk_i, .sys_rst_i, .ce_i(1'b1), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .bus(bus));
  ccs_assertions ccs_assertions_inst (.clk_i, .sys_rst_i, .reg_wr(bus.reg_wr),
    .reg_rd(bus.reg_rd), .reg_idx(bus.reg_idx), .reg_wdata(bus.reg_wdata),
    .reg_rdata(bus.reg_rdata), .reg_ack(bus.reg_ack), .halt_req(bus.halt_req),
    .stop_req(bus.stop_req), .cpu_state(bus.cpu_state));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // One Avalon cycle; the request holds until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    input logic k);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_writedata_chk <= k;
    @(posedge clk_i);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      n_errors++;
      finish_test();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_writedata_chk <= 1'b0;
    @(posedge clk_i);
  endtask

  // Note the expected status, then read it for the monitor to judge
  task automatic chkread(input ccs_state_t s);
    exp_q.push_back({23'h0, 1'b0, 4'h0, 4'(s)});
    av(1'b0, CTL_STAT_OFS, 32'h0, 1'b1);
  endtask

  // Monitor compares each flagged read answer with the oldest note
  always @(posedge clk_i) begin
    if (avs_read && avs_writedata_chk && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) n_errors++;
      else check(avs_readdata, exp_q.pop_front());
    end
  end

  // Run one command, wait out busy, check the state; wake from standby
  task automatic step(input int k);
    int n;
    ccs_state_t e;
    n = 0;
    case (k)
      0: e = ST_INT_RUN;
      1, 2: e = ST_HS_RUN;
      3, 4: e = ST_SUB_RUN;
      5: e = cur == ST_INT_RUN ? ST_HALT_INT : cur == ST_HS_RUN ? ST_HALT_HS : ST_HALT_SUB;
      default: e = cur == ST_INT_RUN ? ST_STOP_INT : ST_STOP_HS;
    endcase
    av(1'b1, CTL_CMD_OFS, 32'(k), 1'b0);
    q = 32'h100;
    while (q[8] !== 1'b0 && n < 3000) begin
      av(1'b0, CTL_STAT_OFS, 32'h0, 1'b0);
      n++;
    end
    if (n >= 3000) begin
      n_errors++;
      finish_test();
    end
    chkread(e);
    if (k >= 5) begin
      // Standby must hold the CPU clock low; stop must also hold the peripheral clock low
      check(cpu_clk, 1'b0);
      if (k == 6) check(periph_clk, 1'b0);
      wake_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      wake_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chkread(cur);
    end else cur = e;
  endtask

  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog sized well past the longest command sequence
  initial begin
    #(100 * 90000);
    n_errors++;
    finish_test();
  end

  // Every command from reset, then a supply-held reset, then random commands
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // The state reaches the status word two edges after it changes
    repeat (3) @(posedge clk_i);
    chkread(ST_INT_RUN);
    foreach (c_list[i]) step(c_list[i]);
    strap <= 1'b1;
    supply_ok_i <= 1'b0;
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chkread(ST_RESET);
    supply_ok_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    chkread(ST_INT_RUN);
    cur = ST_INT_RUN;
    repeat (12) begin
      c = $unsigned($random(seed)) % 7;
      if (c == 6 && cur == ST_SUB_RUN) c = 0;
      step(c);
    end
    finish_test();
  end
endmodule // tb
